//--- core/link_default_config_regs.sv
// Purpose: Management register bank holding default link configuration
// Assumes: AXI4-Lite slave, 32-bit data, one outstanding access each way
// Notes: Config outputs hold defaults until software writes them
`default_nettype none
module link_default_config_regs #(
  parameter int LANES = link_cfg_pkg::LANES_DEF,
  parameter int ALIGN_BUF_DEPTH = link_cfg_pkg::ALIGN_BUF_DEF,
  parameter logic [7:0] DEF_OCTETS = link_cfg_pkg::RST_OCTETS,
  parameter logic [4:0] DEF_FRAMES = link_cfg_pkg::RST_FRAMES,
  parameter logic DEF_SCRAMBLE = link_cfg_pkg::RST_SCRAMBLE,
  parameter logic DEF_SYSREF_ALWAYS = link_cfg_pkg::RST_SYSREF_ALWAYS,
  parameter logic DEF_SYSREF_RESYNC = link_cfg_pkg::RST_SYSREF_RESYNC,
  parameter logic [1:0] DEF_SUBCLASS = link_cfg_pkg::RST_SUBCLASS,
  parameter logic DEF_SAMPLE_NEG = link_cfg_pkg::RST_SAMPLE_NEG
) (
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link side
  input wire logic sysrefPin,
  input wire logic resyncReq,
  input wire logic [LANES-1:0] phyResetDone,
  output link_cfg_pkg::link_cfg_s linkCfg,
  output logic sysrefEvent,
  output logic rxEnable
);
  // Caught at elaboration, never at run time
  // Refuse lane counts and buffer sizes the link cannot serve
  if (LANES < link_cfg_pkg::LANES_MIN ||
      LANES > link_cfg_pkg::LANES_MAX) begin : g_lane_chk
    $error("Lane count must lie between one and twelve");
  end
  if (ALIGN_BUF_DEPTH <= int'(DEF_OCTETS) * int'(DEF_FRAMES))
  begin : g_buf_chk
    $error("Alignment buffer must exceed default multiframe");
  end

  // Merge written bytes into an old word under byte strobes
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] strobe
  );
    logic [31:0] res;
    // Start from the held word
    res = oldVal;
    // One strobe bit per byte lane
    for (int b = 0; b < 4; b++) begin
      if (strobe[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Configuration register state
  link_cfg_pkg::link_cfg_s cfg_r;
  link_cfg_pkg::link_cfg_s cfg_nxt;
  // Write channel state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // Read channel state
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  // Submodule results
  logic armedState;
  logic rxEnableInt;

  // Write taken when address and data both present and no response waits
  // Ready guard stops a held request from being taken twice
  wire wrFire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r & ~awready_r;
  wire [11:0] wAddr = s_axi_awaddr;
  // Write decode
  wire wScr = wrFire & (wAddr == link_cfg_pkg::OFF_SCRAMBLE);
  wire wSys = wrFire & (wAddr == link_cfg_pkg::OFF_SYSREF);
  wire wOct = wrFire & (wAddr == link_cfg_pkg::OFF_OCTETS);
  wire wFrm = wrFire & (wAddr == link_cfg_pkg::OFF_FRAMES);
  wire wSub = wrFire & (wAddr == link_cfg_pkg::OFF_SUBCLASS);
  wire wSmp = wrFire & (wAddr == link_cfg_pkg::OFF_SAMPLE);
  wire wStat = wrFire & (wAddr == link_cfg_pkg::OFF_STATUS);
  // Status is read-only, writes to it are accepted and dropped
  wire wHit = wScr | wSys | wOct | wFrm | wSub | wSmp | wStat;

  // Unused bits read back as zero
  // Current words as software sees them
  wire [31:0] scrWord = {31'h0, cfg_r.scrambleEn};
  wire [31:0] sysWord = {15'h0, cfg_r.sysrefOnResync,
                         15'h0, cfg_r.sysrefAlways};
  wire [31:0] octWord = {24'h0, cfg_r.octetsPerFrame};
  wire [31:0] frmWord = {27'h0, cfg_r.framesPerMultiframe};
  wire [31:0] subWord = {30'h0, cfg_r.subclass};
  wire [31:0] smpWord = {31'h0, cfg_r.sysrefSampleNeg};
  wire [31:0] statWord = {30'h0, armedState, rxEnableInt};

  // Strobes act per byte, so the two-bit SYSREF word may change in part
  // Merged write values per register
  wire [31:0] scrNew = mergeBytes(scrWord, s_axi_wdata, s_axi_wstrb);
  wire [31:0] sysNew = mergeBytes(sysWord, s_axi_wdata, s_axi_wstrb);
  wire [31:0] octNew = mergeBytes(octWord, s_axi_wdata, s_axi_wstrb);
  wire [31:0] frmNew = mergeBytes(frmWord, s_axi_wdata, s_axi_wstrb);
  wire [31:0] subNew = mergeBytes(subWord, s_axi_wdata, s_axi_wstrb);
  wire [31:0] smpNew = mergeBytes(smpWord, s_axi_wdata, s_axi_wstrb);

  // Read taken when no answer is pending
  // Same guard keeps a held read from firing twice
  wire rdFire = s_axi_arvalid & ~rvalid_r & ~arready_r;
  wire [11:0] rAddr = s_axi_araddr;
  // Read decode
  wire rScr = rAddr == link_cfg_pkg::OFF_SCRAMBLE;
  wire rSys = rAddr == link_cfg_pkg::OFF_SYSREF;
  wire rOct = rAddr == link_cfg_pkg::OFF_OCTETS;
  wire rFrm = rAddr == link_cfg_pkg::OFF_FRAMES;
  wire rSub = rAddr == link_cfg_pkg::OFF_SUBCLASS;
  wire rSmp = rAddr == link_cfg_pkg::OFF_SAMPLE;
  wire rStat = rAddr == link_cfg_pkg::OFF_STATUS;
  wire rHit = rScr | rSys | rOct | rFrm | rSub | rSmp | rStat;
  // Priority order is harmless, offsets never overlap
  // Read mux, unmapped reads give zero
  wire [31:0] rMux =
    rScr ? scrWord :
    rSys ? sysWord :
    rOct ? octWord :
    rFrm ? frmWord :
    rSub ? subWord :
    rSmp ? smpWord :
    rStat ? statWord : 32'h0;

  // Unwritten fields keep their value
  // Next configuration, written fields replace held values
  always_comb begin
    cfg_nxt = cfg_r;
    // Scrambling enable, bit 0 only
    if (wScr) begin
      cfg_nxt.scrambleEn = scrNew[0];
    end
    // Both SYSREF bits share one word
    if (wSys) begin
      cfg_nxt.sysrefAlways = sysNew[link_cfg_pkg::SYSREF_ALWAYS_BIT];
      cfg_nxt.sysrefOnResync = sysNew[link_cfg_pkg::SYSREF_RESYNC_BIT];
    end
    // Octets per frame, stored as written
    if (wOct) begin
      cfg_nxt.octetsPerFrame = octNew[link_cfg_pkg::OCTETS_W-1:0];
    end
    // Frames per multiframe, stored as written
    if (wFrm) begin
      cfg_nxt.framesPerMultiframe = frmNew[link_cfg_pkg::FRAMES_W-1:0];
    end
    // Subclass select
    if (wSub) begin
      cfg_nxt.subclass = subNew[link_cfg_pkg::SUBCLASS_W-1:0];
    end
    // Sampling edge, 1 picks the falling edge
    if (wSmp) begin
      cfg_nxt.sysrefSampleNeg = smpNew[0];
    end
  end

  // Configuration registers load generation defaults at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Generation-time defaults from the parameters
      cfg_r.octetsPerFrame <= DEF_OCTETS;
      cfg_r.framesPerMultiframe <= DEF_FRAMES;
      cfg_r.scrambleEn <= DEF_SCRAMBLE;
      cfg_r.sysrefAlways <= DEF_SYSREF_ALWAYS;
      cfg_r.sysrefOnResync <= DEF_SYSREF_RESYNC;
      cfg_r.subclass <= DEF_SUBCLASS;
      cfg_r.sysrefSampleNeg <= DEF_SAMPLE_NEG;
    end else begin
      // Whole struct moves at once
      cfg_r <= cfg_nxt;
    end
  end

  // One write in flight, so no queue is needed
  // Write channel: ready pulses one cycle, response held until taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= link_cfg_pkg::RESP_OKAY;
    end else begin
      // Readies echo the take for one cycle
      awready_r <= wrFire;
      wready_r <= wrFire;
      if (wrFire) begin
        // Response raised with the register update
        bvalid_r <= 1'b1;
        // Unmapped writes change nothing and report an error
        bresp_r <= wHit ? link_cfg_pkg::RESP_OKAY
                        : link_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        // Master took the response
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: data sampled at acceptance, held until taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= link_cfg_pkg::RESP_OKAY;
      rdata_r <= 32'h0;
    end else begin
      // Ready echoes the take for one cycle
      arready_r <= rdFire;
      if (rdFire) begin
        // Data frozen at acceptance
        rvalid_r <= 1'b1;
        rdata_r <= rMux;
        rresp_r <= rHit ? link_cfg_pkg::RESP_OKAY
                        : link_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        // Master took the data
        rvalid_r <= 1'b0;
      end
    end
  end

  // SYSREF sampling steered by the live configuration
  // Capture keeps its own arm state, shown in status
  sysref_capture u_sysref (
    .clk(clk),
    .reset_n(reset_n),
    .sysrefPin(sysrefPin),
    .sampleNeg(cfg_r.sysrefSampleNeg),
    .alwaysMode(cfg_r.sysrefAlways),
    .resyncReq(resyncReq),
    .resyncNeedsSysref(cfg_r.sysrefOnResync),
    .sysrefEvent(sysrefEvent),
    .armed(armedState)
  );

  // Receiver enable waits for every PHY to finish reset
  // Synchroniser inside, so the enable lags three cycles
  reset_done_combiner #(
    .LANES(LANES)
  ) u_done (
    .clk(clk),
    .reset_n(reset_n),
    .phyDoneIn(phyResetDone),
    .rxEnable(rxEnableInt)
  );

  // Nothing combinational on the way out
  // Outputs straight from flops; config usable with no master attached
  assign linkCfg = cfg_r;
  assign rxEnable = rxEnableInt;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

//--- core/reset_done_combiner.sv
// Purpose: Combine per-PHY reset-done levels into one receiver enable
// Assumes: Each done level is asynchronous to clk
// Notes: Enable drops three cycles after any PHY falls back into reset
`default_nettype none
module reset_done_combiner #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [LANES-1:0] phyDoneIn,
  output logic rxEnable
);
  // Two-flop synchroniser, first stage feeds only the second
  logic [LANES-1:0] doneMeta_r;
  logic [LANES-1:0] doneSync_r;
  // All PHYs finished reset
  wire allDone = &doneSync_r;

  // Synchronise every done level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      doneMeta_r <= '0;
      doneSync_r <= '0;
    end else begin
      doneMeta_r <= phyDoneIn;
      doneSync_r <= doneMeta_r;
    end
  end

  // Enable only once every lane reports done
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxEnable <= 1'b0;
    end else begin
      rxEnable <= allDone;
    end
  end
endmodule
`default_nettype wire

//--- core/sysref_capture.sv
// Purpose: Sample the SYSREF pin and issue qualified capture pulses
// Assumes: SYSREF is asynchronous and wider than one clock period
// Notes: Sampling edge choice shifts the capture pulse by zero or one whole cycle
`default_nettype none
module sysref_capture (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sysrefPin,
  input wire logic sampleNeg,
  input wire logic alwaysMode,
  input wire logic resyncReq,
  input wire logic resyncNeedsSysref,
  output logic sysrefEvent,
  output logic armed
);
  // Rising-edge capture path
  logic posMeta_r;
  logic posSync_r;
  // Falling-edge capture path, retimed to the rising edge
  logic negMeta_r;
  logic negSync_r;
  // Previous selected sample for edge detection
  logic last_r;
  // Selected path, only second stages are read
  wire sel = sampleNeg ? negSync_r : posSync_r;
  wire rise = sel & ~last_r;
  wire take = rise & (alwaysMode | armed);

  // Rising-edge sampler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      posMeta_r <= 1'b0;
      posSync_r <= 1'b0;
      negSync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      posMeta_r <= sysrefPin;
      posSync_r <= posMeta_r;
      negSync_r <= negMeta_r;
      last_r <= sel;
    end
  end

  // Falling-edge sampler of the same clock
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      negMeta_r <= 1'b0;
    end else begin
      negMeta_r <= sysrefPin;
    end
  end

  // Arming: one capture per arm unless always mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b1;
      sysrefEvent <= 1'b0;
    end else begin
      sysrefEvent <= take;
      // Re-arm beats disarm in the same cycle
      if (resyncReq && resyncNeedsSysref) begin
        armed <= 1'b1;
      end else if (take && !alwaysMode) begin
        armed <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- include/link_cfg_pkg.sv
// Purpose: Shared constants and types for the link default config bank
// Assumes: 32-bit management data, word-aligned register offsets
// Notes: Reset defaults here are only the default parameter values
`default_nettype none
package link_cfg_pkg;
  // Management bus widths
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  // Register byte offsets
  localparam logic [11:0] OFF_SCRAMBLE = 12'h00c;
  localparam logic [11:0] OFF_SYSREF = 12'h010;
  localparam logic [11:0] OFF_OCTETS = 12'h020;
  localparam logic [11:0] OFF_FRAMES = 12'h024;
  localparam logic [11:0] OFF_SUBCLASS = 12'h02c;
  localparam logic [11:0] OFF_STATUS = 12'h030;
  localparam logic [11:0] OFF_SAMPLE = 12'h034;
  // Field positions and widths
  localparam int SYSREF_ALWAYS_BIT = 0;
  localparam int SYSREF_RESYNC_BIT = 16;
  localparam int OCTETS_W = 8;
  localparam int FRAMES_W = 5;
  localparam int SUBCLASS_W = 2;
  localparam int STAT_RXEN_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  // Reset defaults, chosen at generation time
  localparam logic [7:0] RST_OCTETS = 8'h01;
  localparam logic [4:0] RST_FRAMES = 5'h1f;
  localparam logic RST_SCRAMBLE = 1'b1;
  localparam logic RST_SYSREF_ALWAYS = 1'b0;
  localparam logic RST_SYSREF_RESYNC = 1'b0;
  localparam logic [1:0] RST_SUBCLASS = 2'h1;
  localparam logic RST_SAMPLE_NEG = 1'b1;
  // Lane limits and receive alignment buffer default
  localparam int LANES_MIN = 1;
  localparam int LANES_MAX = 12;
  localparam int LANES_DEF = 2;
  localparam int ALIGN_BUF_DEF = 1024;
  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Live link configuration handed to the datapath
  typedef struct packed {
    logic [7:0] octetsPerFrame;
    logic [4:0] framesPerMultiframe;
    logic scrambleEn;
    logic sysrefAlways;
    logic sysrefOnResync;
    logic [1:0] subclass;
    logic sysrefSampleNeg;
  } link_cfg_s;
endpackage
`default_nettype wire

//--- verification/link_cfg_properties.sv
// Purpose: Port-level timing and value checks on the config bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the bank
`default_nettype none
module link_cfg_properties #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LANES-1:0] phyResetDone,
  input wire link_cfg_pkg::link_cfg_s linkCfg,
  input wire logic sysrefEvent,
  input wire logic rxEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire allPhyDone = &phyResetDone; // Every PHY reports done
  wire takeW = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    && !s_axi_awready; // Write accepted this edge
  wire takeR = s_axi_arvalid && !s_axi_rvalid
    && !s_axi_arready; // Read accepted this edge
  // Acceptance followed by the one-cycle answer
  sequence wrDone;
    takeW ##1 (s_axi_bvalid && s_axi_awready && s_axi_wready);
  endsequence
  sequence rdDone;
    takeR ##1 (s_axi_rvalid && s_axi_arready);
  endsequence
  a_write_answer_timing: assert property (takeW |-> wrDone)
    else $error("write answer late");
  a_read_answer_timing: assert property (takeR |-> rdDone)
    else $error("read answer late");
  a_octets_take_write: assert property (
    takeW ##0 (s_axi_wstrb[0] && s_axi_awaddr == link_cfg_pkg::OFF_OCTETS)
    |=> linkCfg.octetsPerFrame == $past(s_axi_wdata[7:0]))
    else $error("octets field missed write");
  a_cfg_holds_idle: assert property (!takeW |=> $stable(linkCfg))
    else $error("config moved without write");
  a_bvalid_drops_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drops_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rx_needs_all: assert property (
    rxEnable |-> $past(allPhyDone, 3))
    else $error("receiver enabled early");
  a_rx_drop_timing: assert property (!allPhyDone |-> ##3 !rxEnable)
    else $error("receiver enable did not drop");
  a_event_single_cycle: assert property (sysrefEvent |=> !sysrefEvent)
    else $error("capture pulse too long");
endmodule
bind link_default_config_regs link_cfg_properties #(.LANES(LANES)) chk_u (
  .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .phyResetDone(phyResetDone), .linkCfg(linkCfg),
  .sysrefEvent(sysrefEvent), .rxEnable(rxEnable));
`default_nettype wire

//--- verification/phy_reset_model.sv
// Purpose: Behavioural PHY group driving per-lane reset-done levels
// Assumes: Lanes finish reset at staggered times after restart
// Notes: Lane 0 can be knocked back into reset to test the drop path
`default_nettype none
module phy_reset_model #(
  parameter int LANES = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restartPhy,
  input wire logic dropLane,
  output logic [LANES-1:0] phyDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] count_r; // Cycles since restart, saturating
  // Counter saturates so no lane ever falls back on its own
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 8'h00;
    end else if (restartPhy) begin
      count_r <= 8'h00;
    end else if (count_r != 8'hff) begin
      count_r <= count_r + 8'h01;
    end
  end
  // Staggered finish so the last lane alone gates the enable
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      phyDone[i] = (count_r > 8'(4 + 3 * i)) && !(dropLane && i == 0);
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: Self-checking bench for the link default config bank
// Assumes: Bus answers within 20 cycles, PHY model on the done inputs
// Notes: Response ready lines are held high throughout the run
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 3; // Odd lane count inside the range
  logic clk = 1'h0, reset_n = 1'h0;
  logic awValid = 1'h0, wValid = 1'h0, arValid = 1'h0, sysrefPin = 1'h0;
  logic restartPhy = 1'h1, dropLane = 1'h0, resyncReq = 1'h0;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid, rxEnable, sysrefEvent;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [LANES-1:0] phyDone;
  link_cfg_pkg::link_cfg_s linkCfg, expCfg; // Live and predicted config
  int num_errors = 0, checks_done = 0, cycles = 0;
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  // Default alignment buffer outlasts any default multiframe
  link_default_config_regs #(.LANES(LANES)) dut_u (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(1'h1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(1'h1), .sysrefPin(sysrefPin),
    .resyncReq(resyncReq), .phyResetDone(phyDone), .linkCfg(linkCfg),
    .sysrefEvent(sysrefEvent), .rxEnable(rxEnable));
  phy_reset_model #(.LANES(LANES)) phy_u (.clk(clk), .reset_n(reset_n),
    .restartPhy(restartPhy), .dropLane(dropLane), .phyDone(phyDone));
  // Single comparison helper; unknowns never match
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data offered together, held until the response
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] expResp);
    int n;
    n = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (bValid !== 1'h1 && n < 20);
    awValid <= 1'h0;
    wValid <= 1'h0;
    check_word({31'h0, bValid}, 32'h1);
    check_word({30'h0, bResp}, {30'h0, expResp});
  endtask
  // Read held until valid data is seen at a rising edge
  task automatic axi_read(input logic [11:0] a, input logic [31:0] expData,
      input logic [1:0] expResp);
    int n;
    n = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (rValid !== 1'h1 && n < 20);
    arValid <= 1'h0;
    check_word({31'h0, rValid}, 32'h1);
    check_word(rData, expData);
    check_word({30'h0, rResp}, {30'h0, expResp});
  endtask
  // Live config and all registers but sample and status come up at generated defaults
  task automatic test_defaults();
    expCfg = {link_cfg_pkg::RST_OCTETS, link_cfg_pkg::RST_FRAMES,
      link_cfg_pkg::RST_SCRAMBLE, link_cfg_pkg::RST_SYSREF_ALWAYS,
      link_cfg_pkg::RST_SYSREF_RESYNC, link_cfg_pkg::RST_SUBCLASS,
      link_cfg_pkg::RST_SAMPLE_NEG};
    check_word({13'h0, linkCfg}, {13'h0, expCfg});
    axi_read(link_cfg_pkg::OFF_OCTETS, {24'h0, link_cfg_pkg::RST_OCTETS},
      link_cfg_pkg::RESP_OKAY);
    axi_read(link_cfg_pkg::OFF_FRAMES, {27'h0, link_cfg_pkg::RST_FRAMES},
      link_cfg_pkg::RESP_OKAY);
    axi_read(link_cfg_pkg::OFF_SCRAMBLE, {31'h0,
      link_cfg_pkg::RST_SCRAMBLE}, link_cfg_pkg::RESP_OKAY);
    axi_read(link_cfg_pkg::OFF_SYSREF, {15'h0,
      link_cfg_pkg::RST_SYSREF_RESYNC, 15'h0,
      link_cfg_pkg::RST_SYSREF_ALWAYS}, link_cfg_pkg::RESP_OKAY);
    axi_read(link_cfg_pkg::OFF_SUBCLASS, {30'h0,
      link_cfg_pkg::RST_SUBCLASS}, link_cfg_pkg::RESP_OKAY);
    $display("test defaults finished");
  endtask
  // Back-to-back writes replace defaults; empty strobe changes nothing
  task automatic test_write_back();
    axi_write(link_cfg_pkg::OFF_OCTETS, 32'ha5, 4'hf, 2'h0);
    axi_write(link_cfg_pkg::OFF_OCTETS, 32'h3c, 4'h0, 2'h0);
    axi_write(link_cfg_pkg::OFF_FRAMES, 32'h0a, 4'hf, 2'h0);
    axi_write(link_cfg_pkg::OFF_SCRAMBLE, 32'h0, 4'hf, 2'h0);
    axi_write(link_cfg_pkg::OFF_SYSREF, 32'h10001, 4'hf, 2'h0);
    axi_write(link_cfg_pkg::OFF_SUBCLASS, 32'h2, 4'hf, 2'h0);
    expCfg.octetsPerFrame = 8'ha5;
    expCfg.framesPerMultiframe = 5'h0a;
    expCfg.scrambleEn = 1'h0;
    expCfg.sysrefAlways = 1'h1;
    expCfg.sysrefOnResync = 1'h1;
    expCfg.subclass = 2'h2;
    check_word({13'h0, linkCfg}, {13'h0, expCfg});
    axi_read(link_cfg_pkg::OFF_OCTETS, 32'ha5, 2'h0);
    axi_read(link_cfg_pkg::OFF_FRAMES, 32'h0a, 2'h0);
    axi_read(link_cfg_pkg::OFF_SCRAMBLE, 32'h0, 2'h0);
    axi_read(link_cfg_pkg::OFF_SYSREF, 32'h10001, 2'h0);
    axi_read(link_cfg_pkg::OFF_SUBCLASS, 32'h2, 2'h0);
    $display("test write back finished");
  endtask
  // Unmapped place refused, read-only status write has no effect
  task automatic test_unmapped();
    axi_write(12'h100, 32'hdeadbeef, 4'hf, link_cfg_pkg::RESP_SLVERR);
    axi_read(12'h100, 32'h0, link_cfg_pkg::RESP_SLVERR);
    axi_write(link_cfg_pkg::OFF_STATUS, 32'hff, 4'hf, 2'h0);
    check_word({13'h0, linkCfg}, {13'h0, expCfg});
    $display("test unmapped finished");
  endtask
  // Enable waits for the slowest lane and drops when lane 0 drops
  task automatic test_rx_enable();
    int n, tAll, tEn;
    tAll = -1;
    tEn = -1;
    @(posedge clk);
    restartPhy <= 1'h0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (tAll < 0 && &phyDone) tAll = n;
      if (tEn < 0 && rxEnable === 1'h1) tEn = n;
    end
    check_word(32'(tEn - tAll), 32'h3);
    dropLane <= 1'h1;
    repeat (4) @(posedge clk);
    check_word({31'h0, rxEnable}, 32'h0);
    dropLane <= 1'h0;
    $display("test rx enable finished");
  endtask
  // Capture pulses over one SYSREF pulse, counted against expCount
  task automatic pulse_sysref(input logic [31:0] expCount);
    int n;
    logic [31:0] seen;
    seen = 32'h0;
    @(posedge clk);
    sysrefPin <= 1'h1;
    for (n = 0; n < 12; n++) begin
      @(posedge clk);
      if (n == 4) sysrefPin <= 1'h0;
      if (sysrefEvent === 1'h1) seen++;
    end
    check_word(seen, expCount);
  endtask
  // Both sampling edges, capture on every pulse enabled
  task automatic test_sysref();
    axi_write(link_cfg_pkg::OFF_SYSREF, 32'h1, 4'hf, 2'h0);
    for (int e = 0; e < 2; e++) begin
      axi_write(link_cfg_pkg::OFF_SAMPLE, 32'(e), 4'hf, 2'h0);
      axi_read(link_cfg_pkg::OFF_SAMPLE, 32'(e), 2'h0);
      pulse_sysref(32'h1);
      pulse_sysref(32'h1);
    end
    // One capture per arming, a resync request re-arms
    axi_write(link_cfg_pkg::OFF_SYSREF, 32'h10000, 4'hf, 2'h0);
    pulse_sysref(32'h1);
    pulse_sysref(32'h0);
    axi_read(link_cfg_pkg::OFF_STATUS, 32'h1, 2'h0);
    resyncReq <= 1'h1;
    @(posedge clk);
    resyncReq <= 1'h0;
    pulse_sysref(32'h1);
    $display("test sysref finished");
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    test_defaults();
    test_write_back();
    test_unmapped();
    test_rx_enable();
    test_sysref();
    // Mid-run reset must bring every default back
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    test_defaults();
    wrap_up();
  end
endmodule
`default_nettype wire
